// [rtl/imp_pkg.sv]
// package for the indexed move and pointer instruction unit
// ----------------------------------------------------------------
// Function
// - move_indexed_to_absolute reads from frame_pointer_two plus the 7-bit offset of word one.
// - move_indexed_to_absolute writes to the 12-bit address carried in word two.
// - every source and destination address may be anywhere from 000h to fffh.
// - a source address that hits an indirect-addressing register yields data 00h.
// - move_indexed_to_absolute is 1110 1011 0 plus offset, then 1111 plus the 12-bit address.
// - move_indexed_to_indexed is 1110 1011 1 plus offset, then 1111, don't-cares, 7-bit offset.
// - move_indexed_to_indexed adds each 7-bit offset to frame_pointer_two.
// - an indexed destination that hits an indirect-addressing register gives no write (nop).
// - push_literal writes the 8-bit literal at frame_pointer_two, then decrements it, in one cycle.
// - subtract_literal_from_pointer subtracts a 6-bit literal from pointer 0, 1 or 2.
// - subtract_literal_from_pointer is 1110 1001 ff kkkkkk, one word, one cycle, flags untouched.
// ----------------------------------------------------------------
package imp_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int NUM_PTR = 3;
  localparam logic [7:0] OPC_MOVE_IDX = 8'heb;
  localparam logic [7:0] OPC_PUSH_LIT = 8'hfa;
  localparam logic [7:0] OPC_SUB_PTR = 8'he9;
  localparam logic [3:0] OPC_SECOND = 4'hf;
  localparam logic [11:0] PTR_RST = 12'h000;
  localparam logic [7:0] ZERO_DATA = 8'h00;
  localparam logic [1:0] SEL_FP2 = 2'h2;

  typedef enum logic [1:0] {
    IMP_IDLE = 2'b00,
    IMP_SECOND = 2'b01
  } imp_state_e;

  typedef struct packed {
    logic en;
    logic [11:0] addr;
    logic [7:0] data;
  } imp_wr_s;
endpackage

// [rtl/imp_ptr_file.sv]
// three 12-bit pointer registers with one write port
`timescale 1ns/1ps
module imp_ptr_file (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [1:0] wr_sel,
  input wire logic [imp_pkg::ADDR_W-1:0] wr_val,
  output logic [3*imp_pkg::ADDR_W-1:0] ptr_flat
);
  import imp_pkg::*;
  logic [ADDR_W-1:0] ptr_ff [NUM_PTR];
  logic [ADDR_W-1:0] nxt_ptr [NUM_PTR];

  genvar i;
  generate
    for (i = 0; i < NUM_PTR; i++) begin : g_ptr
      always_comb begin
        nxt_ptr[i] = ptr_ff[i];
        if (wr_en && (wr_sel == 2'(i))) begin
          nxt_ptr[i] = wr_val;
        end
      end
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          ptr_ff[i] <= PTR_RST;
        end else begin
          ptr_ff[i] <= nxt_ptr[i];
        end
      end
      assign ptr_flat[i*ADDR_W +: ADDR_W] = ptr_ff[i];
    end
  endgenerate
endmodule

// [rtl/imp_exec.sv]
// execution unit for indexed moves, literal push and pointer subtract
`timescale 1ns/1ps
module imp_exec (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [imp_pkg::DATA_W-1:0] mem_rd_data,
  input wire logic mem_rd_indirect,
  input wire logic [imp_pkg::ADDR_W-1:0] dst_indirect_mask,
  output logic [imp_pkg::ADDR_W-1:0] mem_rd_addr,
  output imp_pkg::imp_wr_s mem_wr,
  output logic [imp_pkg::ADDR_W-1:0] fp2_out,
  output logic busy,
  output logic instr_done,
  output logic illegal_op
);
  import imp_pkg::*;

  // ----------------------------------------------------------------
  // pointer storage
  // ----------------------------------------------------------------
  logic ptr_we;
  logic [1:0] ptr_sel;
  logic [ADDR_W-1:0] ptr_val;
  logic [3*ADDR_W-1:0] ptr_flat;
  logic [ADDR_W-1:0] fp2;

  imp_ptr_file u_ptr (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(ptr_we),
    .wr_sel(ptr_sel),
    .wr_val(ptr_val),
    .ptr_flat(ptr_flat)
  );
  assign fp2 = ptr_flat[2*ADDR_W +: ADDR_W];

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic dec_move;
  logic dec_push;
  logic dec_sub;
  logic dec_sub_bad;
  logic [ADDR_W-1:0] src_sum;
  logic [ADDR_W-1:0] dst_sum;
  logic [ADDR_W-1:0] sub_res;
  logic [ADDR_W-1:0] sel_ptr;

  assign dec_move = instr_word[15:8] == OPC_MOVE_IDX;
  assign dec_push = instr_word[15:8] == OPC_PUSH_LIT;
  // select 3 belongs to the add-and-return neighbour, flagged here only
  assign dec_sub = (instr_word[15:8] == OPC_SUB_PTR) && (instr_word[7:6] != 2'h3);
  assign dec_sub_bad = (instr_word[15:8] == OPC_SUB_PTR) && (instr_word[7:6] == 2'h3);
  // sums keep 12 bits so the wrap falls out naturally
  assign src_sum = fp2 + {5'h00, instr_word[6:0]};
  assign sel_ptr = ptr_flat[instr_word[7:6]*ADDR_W +: ADDR_W];
  assign sub_res = sel_ptr - {6'h00, instr_word[5:0]};

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  imp_state_e state_ff, nxt_state;
  logic kind_ff, nxt_kind;
  logic [DATA_W-1:0] data_ff, nxt_data;
  logic [ADDR_W-1:0] rd_addr_ff, nxt_rd_addr;
  imp_wr_s wr_ff, nxt_wr;
  logic done_ff, nxt_done;
  logic ill_ff, nxt_ill;
  logic busy_ff, nxt_busy;

  assign dst_sum = fp2 + {5'h00, instr_word[6:0]};

  always_comb begin
    nxt_state = state_ff;
    nxt_kind = kind_ff;
    nxt_data = data_ff;
    nxt_rd_addr = rd_addr_ff;
    nxt_wr = '0;
    nxt_done = 1'b0;
    nxt_ill = 1'b0;
    ptr_we = 1'b0;
    ptr_sel = SEL_FP2;
    ptr_val = fp2;
    unique case (state_ff)
      IMP_IDLE: begin
        if (instr_valid && dec_move) begin
          nxt_kind = instr_word[7];
          nxt_rd_addr = src_sum;
          nxt_state = IMP_SECOND;
        end else if (instr_valid && dec_push) begin
          nxt_wr.en = 1'b1;
          nxt_wr.addr = fp2;
          nxt_wr.data = instr_word[7:0];
          ptr_we = 1'b1;
          ptr_val = fp2 - 12'h001;
          nxt_done = 1'b1;
        end else if (instr_valid && dec_sub) begin
          ptr_we = 1'b1;
          ptr_sel = instr_word[7:6];
          ptr_val = sub_res;
          nxt_done = 1'b1;
        end else if (instr_valid) begin
          nxt_ill = dec_sub_bad;
        end
      end
      IMP_SECOND: begin
        // source read is captured in the second cycle, together with the second word
        nxt_data = mem_rd_indirect ? ZERO_DATA : mem_rd_data;
        if (instr_valid) begin
          nxt_state = IMP_IDLE;
          nxt_done = 1'b1;
          nxt_wr.data = nxt_data;
          if (kind_ff) begin
            nxt_wr.addr = dst_sum;
            // indirect-register destination turns into a nop
            nxt_wr.en = (instr_word[15:12] == OPC_SECOND) &&
                        !dst_indirect_mask[0];
          end else begin
            nxt_wr.addr = instr_word[11:0];
            nxt_wr.en = instr_word[15:12] == OPC_SECOND;
          end
          nxt_ill = instr_word[15:12] != OPC_SECOND;
        end
      end
      default: begin
        nxt_state = IMP_IDLE;
      end
    endcase
    // busy gets its own flop so the port is not a decode of the state
    nxt_busy = nxt_state == IMP_SECOND;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff <= IMP_IDLE;
      kind_ff <= 1'b0;
      data_ff <= ZERO_DATA;
      rd_addr_ff <= PTR_RST;
      wr_ff <= '0;
      done_ff <= 1'b0;
      ill_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      kind_ff <= nxt_kind;
      data_ff <= nxt_data;
      rd_addr_ff <= nxt_rd_addr;
      wr_ff <= nxt_wr;
      done_ff <= nxt_done;
      ill_ff <= nxt_ill;
      busy_ff <= nxt_busy;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign mem_rd_addr = rd_addr_ff;
  assign mem_wr = wr_ff;
  assign fp2_out = fp2;
  assign busy = busy_ff;
  assign instr_done = done_ff;
  assign illegal_op = ill_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_push_issue;
    (state_ff == IMP_IDLE) && instr_valid && dec_push;
  endsequence

  a_push_write: assert property (@(posedge clk_sys) disable iff (rst)
    s_push_issue |=> mem_wr.en && (mem_wr.addr == $past(fp2)) &&
      (mem_wr.data == $past(instr_word[7:0])))
    else $error("push write wrong");

  a_push_dec: assert property (@(posedge clk_sys) disable iff (rst)
    s_push_issue |=> fp2 == $past(fp2) - 12'h001)
    else $error("push decrement wrong");

  a_sub_ptr: assert property (@(posedge clk_sys) disable iff (rst)
    (state_ff == IMP_IDLE) && instr_valid && dec_sub && (instr_word[7:6] == SEL_FP2)
    |=> fp2 == $past(fp2) - {6'h00, $past(instr_word[5:0])})
    else $error("subtract result wrong");

  a_sub_nowrite: assert property (@(posedge clk_sys) disable iff (rst)
    (state_ff == IMP_IDLE) && instr_valid && dec_sub |=> !mem_wr.en && instr_done)
    else $error("subtract touched memory");

  a_move_src: assert property (@(posedge clk_sys) disable iff (rst)
    (state_ff == IMP_IDLE) && instr_valid && dec_move
    |=> busy && (mem_rd_addr == $past(fp2) + {5'h00, $past(instr_word[6:0])}))
    else $error("move source address wrong");

  a_move_two: assert property (@(posedge clk_sys) disable iff (rst)
    (state_ff == IMP_IDLE) && instr_valid && dec_move ##1 instr_valid
    |=> !busy && instr_done)
    else $error("move not two cycles");

  a_move_abs: assert property (@(posedge clk_sys) disable iff (rst)
    busy && !kind_ff && instr_valid && (instr_word[15:12] == OPC_SECOND)
    |=> mem_wr.en && (mem_wr.addr == $past(instr_word[11:0])))
    else $error("absolute destination wrong");

  a_src_zero: assert property (@(posedge clk_sys) disable iff (rst)
    busy && instr_valid && mem_rd_indirect |=> mem_wr.data == ZERO_DATA)
    else $error("indirect source not zero");

  a_dst_nop: assert property (@(posedge clk_sys) disable iff (rst)
    busy && kind_ff && instr_valid && dst_indirect_mask[0] |=> !mem_wr.en)
    else $error("indirect destination written");

  a_sub_sel3: assert property (@(posedge clk_sys) disable iff (rst)
    (state_ff == IMP_IDLE) && instr_valid && dec_sub_bad
    |=> illegal_op && !instr_done && $stable(fp2))
    else $error("select three executed");

  a_idx_dst: assert property (@(posedge clk_sys) disable iff (rst)
    busy && kind_ff && instr_valid && (instr_word[15:12] == OPC_SECOND) && !dst_indirect_mask[0]
    |=> mem_wr.en && (mem_wr.addr == $past(fp2) + {5'h00, $past(instr_word[6:0])}))
    else $error("indexed destination wrong");

  a_bad_second: assert property (@(posedge clk_sys) disable iff (rst)
    busy && instr_valid && (instr_word[15:12] != OPC_SECOND) |=> illegal_op && !mem_wr.en)
    else $error("bad second word written");
endmodule

// [tb/indexed_move_pointer_ops_tb.sv]
// self-checking testbench for the indexed move and pointer instruction unit
`timescale 1ns/1ps
module indexed_move_pointer_ops_tb;
  import imp_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [DATA_W-1:0] mem_rd_data = 8'h00;
  logic mem_rd_indirect = 1'b0;
  logic [ADDR_W-1:0] dst_indirect_mask = 12'h000;
  logic [ADDR_W-1:0] mem_rd_addr;
  imp_wr_s mem_wr;
  logic [ADDR_W-1:0] fp2_out;
  logic busy;
  logic instr_done;
  logic illegal_op;
  logic [ADDR_W-1:0] fp;
  int bad_count = 0;
  int n_tests = 0;

  always #5 clk_sys = ~clk_sys;

  imp_exec u_imp_exec (
    .clk_sys(clk_sys),
    .rst(rst),
    .instr_valid(instr_valid),
    .instr_word(instr_word),
    .mem_rd_data(mem_rd_data),
    .mem_rd_indirect(mem_rd_indirect),
    .dst_indirect_mask(dst_indirect_mask),
    .mem_rd_addr(mem_rd_addr),
    .mem_wr(mem_wr),
    .fp2_out(fp2_out),
    .busy(busy),
    .instr_done(instr_done),
    .illegal_op(illegal_op)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one word per call; the edge after it takes the word, outputs read 1 ns later
  task automatic issue(input logic [15:0] w);
    @(posedge clk_sys) #1;
    instr_valid = 1'b1;
    instr_word = w;
    @(posedge clk_sys) #1;
    instr_valid = 1'b0;
    instr_word = ~w;
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_push(input logic [7:0] k);
    issue({OPC_PUSH_LIT, k});
    chk("push wr_en", 1, mem_wr.en);
    chk("push addr", fp, mem_wr.addr);
    chk("push data", k, mem_wr.data);
    fp = fp - 12'h001;
    chk("push fp2", fp, fp2_out);
    chk("push done", 1, instr_done);
    @(posedge clk_sys) #1;
    chk("push pulse", 0, mem_wr.en);
  endtask

  task automatic t_sub(input logic [1:0] sel, input logic [5:0] k);
    issue({OPC_SUB_PTR, sel, k});
    if (sel == SEL_FP2) fp = fp - {6'h00, k};
    chk("sub fp2", fp, fp2_out);
    chk("sub illegal", sel == 2'h3, illegal_op);
    chk("sub done", sel != 2'h3, instr_done);
  endtask

  task automatic t_move_abs(input logic ind, input logic [11:0] dst, input logic [6:0] zs);
    issue({OPC_MOVE_IDX, 1'b0, zs});
    chk("abs src", 12'(fp + {5'h00, zs}), mem_rd_addr);
    chk("abs busy", 1, busy);
    mem_rd_data = 8'h33;
    mem_rd_indirect = ind;
    issue({OPC_SECOND, dst});
    mem_rd_data = 8'hcc;
    mem_rd_indirect = 1'b0;
    chk("abs wr_en", 1, mem_wr.en);
    chk("abs dst", dst, mem_wr.addr);
    chk("abs data", ind ? 8'h00 : 8'h33, mem_wr.data);
    chk("abs idle", 0, busy);
    chk("abs fp2", fp, fp2_out);
  endtask

  task automatic t_move_idx(input logic dind, input logic [6:0] zs, input logic [6:0] zd);
    issue({OPC_MOVE_IDX, 1'b1, zs});
    chk("idx src", 12'(fp + {5'h00, zs}), mem_rd_addr);
    mem_rd_data = 8'h5a;
    dst_indirect_mask = {11'h000, dind};
    issue({OPC_SECOND, 5'h1f, zd});
    mem_rd_data = 8'ha5;
    dst_indirect_mask = 12'h000;
    chk("idx wr_en", !dind, mem_wr.en);
    if (!dind) begin
      chk("idx dst", 12'(fp + {5'h00, zd}), mem_wr.addr);
      chk("idx data", 8'h5a, mem_wr.data);
    end
  endtask

  // a second word without the 1111 prefix must not write
  task automatic t_move_bad;
    issue({OPC_MOVE_IDX, 8'h00});
    issue(16'h0000);
    chk("bad second illegal", 1, illegal_op);
    chk("bad second wr_en", 0, mem_wr.en);
    chk("bad second busy", 0, busy);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    fp = PTR_RST;
    repeat (6) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    chk("rst fp2", 0, fp2_out);
    chk("rst wr_en", 0, mem_wr.en);
    issue(16'h0000);
    chk("unknown done", 0, instr_done);
    t_push(8'h08);
    t_sub(2'h2, 6'h23);
    t_sub(2'h0, 6'h3f);
    t_sub(2'h1, 6'h01);
    t_sub(2'h3, 6'h3f);
    t_move_abs(1'b0, 12'hfff, 7'h7f);
    t_move_abs(1'b1, 12'h000, 7'h05);
    t_move_idx(1'b0, 7'h05, 7'h7f);
    t_move_idx(1'b1, 7'h10, 7'h06);
    t_move_bad();
    t_push(8'hff);
    print_verdict();
  end

  // the whole run needs under 100 cycles; 2000 cycles leaves a wide margin
  initial begin
    #20000;
    bad_count++;
    print_verdict();
  end
endmodule
